/* hw/jdl_cfg.svh */
// register offsets, field positions and reset values of the latency controller
`ifndef JDL_CFG_SVH
`define JDL_CFG_SVH
`define ADDR_IRQ_EN_A 12'h021
`define ADDR_IRQ_EN_B 12'h022
`define ADDR_IRQ_ST_A 12'h025
`define ADDR_IRQ_ST_B 12'h026
`define ADDR_SYNC_CTRL 12'h03a
`define ADDR_SYNC_FLAGS 12'h03b
`define ADDR_SUBCLASS 12'h301
`define ADDR_LAT_L0 12'h302
`define ADDR_LAT_L1 12'h303
`define ADDR_MFDEL_L0 12'h304
`define ADDR_MFDEL_L1 12'h305
`define ADDR_RBD_L0 12'h306
`define ADDR_RBD_L1 12'h307
`define ADDR_LINK_CFG 12'h458
`define ADDR_FRAMING 12'h0f0
`define FLD_LOCK 2'h3
`define FLD_ROTATE 2'h2
`define FLD_WLIM 2'h1
`define FLD_TRIP 2'h0
`define FLD_STICKY_CLR 3'h5
`define FLD_LINK_SUB_LSB 3'h5
`define SUBCLASS_MAX 3'h1
`define RBD_MAX 8'h0a
`define RST_SUBCLASS 3'h0
`define RST_LINK_CFG 8'h0f
`define RST_FRAMING 8'hf9
`define RST_MFDEL 8'h00
`define RST_RBD 8'h00
`define RST_IRQ_EN 4'h0
`endif

/* hw/jdl_pkg.sv */
// shared types of the latency controller
package jdl_pkg;
   typedef enum logic [2:0] {
      REL_IDLE = 3'b001,
      REL_ARMED = 3'b010,
      REL_READ = 3'b100
   } release_state_type;
   typedef logic [3:0] sync_flags_type;
endpackage : jdl_pkg

/* hw/lmfc_if.sv */
// carrier between the controller and one link's release timer
interface lmfc_if;
   logic lmfc_edge;
   logic ilas_done;
   logic lanes_arrived;
   logic active;
   logic [3:0] rx_buffer_release_delay;
   logic [5:0] mf_len;
   logic [5:0] latency;
   logic release_en;
   modport ctrl (output lmfc_edge, ilas_done, lanes_arrived, active, rx_buffer_release_delay, mf_len,
      input latency, release_en);
   modport link (input lmfc_edge, ilas_done, lanes_arrived, active, rx_buffer_release_delay, mf_len,
      output latency, release_en);
endinterface : lmfc_if

/* hw/link_release_timer.sv */
// per-link latency counter, latency capture and receive buffer release
module link_release_timer
   import jdl_pkg::*;
(
   input wire logic ref_clk_in, // parallel clock
   input wire logic nrst_in, // async reset, active low
   lmfc_if.link lk // controller side
);
   logic [5:0] cnt;
   logic [5:0] next_cnt;
   logic [5:0] latency;
   logic [5:0] next_latency;
   release_state_type state;
   release_state_type next_state;
   logic [3:0] rel_cnt;
   logic [3:0] next_rel_cnt;
   logic rel_run;
   logic next_rel_run;
   logic rel_due;

   always_comb begin
      next_cnt = 6'h00;
      if (!lk.lmfc_edge && (cnt + 6'h01 != lk.mf_len)) begin
         next_cnt = cnt + 6'h01;
      end
      next_latency = latency;
      if (lk.ilas_done) begin
         next_latency = next_cnt;
      end
      // release delay may exceed the multiframe, so it keeps its own count
      next_rel_run = rel_run || lk.lmfc_edge;
      next_rel_cnt = rel_run ? rel_cnt + 4'h1 : 4'h0;
      rel_due = next_rel_run && (next_rel_cnt == lk.rx_buffer_release_delay);
      next_state = state;
      unique case (state)
         REL_IDLE: begin
            if (lk.active && lk.lanes_arrived) begin
               next_state = REL_ARMED;
            end
         end
         REL_ARMED: begin
            if (rel_due) begin
               next_state = REL_READ;
            end
         end
         REL_READ: begin
            next_state = REL_READ;
         end
         default: begin
            next_state = REL_IDLE;
         end
      endcase
      if (!lk.active) begin
         next_state = REL_IDLE;
      end
      if (next_state != REL_ARMED) begin
         next_rel_run = 1'b0;
         next_rel_cnt = 4'h0;
      end
   end

   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         cnt <= 6'h00;
         latency <= 6'h00;
         state <= REL_IDLE;
         rel_cnt <= 4'h0;
         rel_run <= 1'b0;
      end else begin
         cnt <= next_cnt;
         latency <= next_latency;
         state <= next_state;
         rel_cnt <= next_rel_cnt;
         rel_run <= next_rel_run;
      end
   end

   assign lk.latency = latency;
   assign lk.release_en = (state == REL_READ);

   property p_release_at_rbd;
      @(posedge ref_clk_in) disable iff (!nrst_in)
      (state == REL_ARMED && lk.active && rel_run && rel_cnt + 4'h1 == lk.rx_buffer_release_delay) |=> lk.release_en;
   endproperty
   a_release_at_rbd: assert property (p_release_at_rbd) else $error("release missed");
   property p_latency_capture;
      @(posedge ref_clk_in) disable iff (!nrst_in)
      lk.ilas_done |=> (latency == cnt);
   endproperty
   a_latency_capture: assert property (p_latency_capture) else $error("bad latency");
   property p_wrap;
      @(posedge ref_clk_in) disable iff (!nrst_in)
      (lk.mf_len != 6'h00) |-> (cnt < lk.mf_len);
   endproperty
   a_wrap: assert property (p_wrap) else $error("latency count past multiframe");
endmodule : link_release_timer

/* hw/sync_irq_pair.sv */
// sync status flags, event enables and pending status of one DAC pair
`include "jdl_cfg.svh"
module sync_irq_pair
   import jdl_pkg::*;
(
   input wire logic ref_clk_in, // parallel clock
   input wire logic nrst_in, // async reset, active low
   input wire logic check_in, // phase check done, pulse
   input wire logic aligned_in, // phase aligned at check
   input wire logic rotated_in, // clock rotation done, pulse
   input wire logic wlim_in, // error beyond window at check
   input wire logic sticky_clr_in, // clear sticky flags, pulse
   input wire logic en_wr_in, // enable register write
   input wire logic st_wr_in, // status register write
   input wire logic [3:0] wdata_in, // write data
   output sync_flags_type flags_out, // lock, rotate, wlim, trip
   output logic [3:0] enable_out, // event enables
   output logic [3:0] status_out, // pending events
   output logic irq_out // any enabled event pending
);
   sync_flags_type flags;
   sync_flags_type next_flags;
   sync_flags_type events;
   logic [3:0] enable;
   logic [3:0] next_enable;
   logic [3:0] status;
   logic [3:0] next_status;

   always_comb begin
      events = '0;
      events[`FLD_LOCK] = check_in && aligned_in;
      events[`FLD_ROTATE] = rotated_in;
      events[`FLD_WLIM] = check_in && wlim_in;
      events[`FLD_TRIP] = check_in;
      next_flags = flags;
      if (sticky_clr_in) begin
         next_flags[`FLD_ROTATE] = 1'b0;
         next_flags[`FLD_TRIP] = 1'b0;
      end
      next_flags[`FLD_ROTATE] = next_flags[`FLD_ROTATE] | rotated_in;
      next_flags[`FLD_TRIP] = next_flags[`FLD_TRIP] | check_in;
      if (check_in) begin
         next_flags[`FLD_LOCK] = aligned_in;
         next_flags[`FLD_WLIM] = wlim_in;
      end
      next_enable = en_wr_in ? wdata_in : enable;
      // a new event beats a clear in the same cycle
      next_status = (st_wr_in ? (status & ~wdata_in) : status) | (events & enable);
   end

   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         flags <= '0;
         enable <= `RST_IRQ_EN;
         status <= 4'h0;
      end else begin
         flags <= next_flags;
         enable <= next_enable;
         status <= next_status;
      end
   end

   assign flags_out = flags;
   assign enable_out = enable;
   assign status_out = status;
   assign irq_out = |(status & enable);

   property p_rotate_sticky;
      @(posedge ref_clk_in) disable iff (!nrst_in)
      (flags[`FLD_ROTATE] && !sticky_clr_in) |=> flags[`FLD_ROTATE];
   endproperty
   a_rotate_sticky: assert property (p_rotate_sticky) else $error("rotate lost");
   property p_lock_update;
      @(posedge ref_clk_in) disable iff (!nrst_in)
      check_in |=> (flags[`FLD_LOCK] == $past(aligned_in)) && (flags[`FLD_WLIM] == $past(wlim_in));
   endproperty
   a_lock_update: assert property (p_lock_update) else $error("lock not updated");
   property p_trip_clear;
      @(posedge ref_clk_in) disable iff (!nrst_in)
      (st_wr_in && wdata_in[0] && !check_in) |=> !status[0] ##1 (irq_out == |(status & enable));
   endproperty
   a_trip_clear: assert property (p_trip_clear) else $error("status not cleared");
   property p_irq_pending;
      @(posedge ref_clk_in) disable iff (!nrst_in)
      (check_in && enable[`FLD_TRIP]) |=> irq_out;
   endproperty
   a_irq_pending: assert property (p_irq_pending) else $error("irq missing");
endmodule : sync_irq_pair

/* hw/jesd_deterministic_latency_ctrl.sv */
// receive deterministic-latency control: local multiframe clocks, release, sync irq
`include "jdl_cfg.svh"

// Operation
// - the four sync status flags are interrupt event sources
// - pair A: enable register bits 3:0, status register bits 3:0 cleared by write
// - pair B: its own enable and status/clear registers, same behaviour
// - only subclass 0 and 1; global field and per-link field both written
// - subclass 0 ignores the sysref input entirely
// - all lanes in one multiframe period; both DAC pairs share one phase
// - subclass 0 with one octet per frame: no error reporting on sync request
// - subclass 1 aligns the multiframe phase to the sysref edge
// - all lanes of a link are read in the same multiframe period
// - each link has a local multiframe clock delayed from the aligned one
// - the variation setting is the receive buffer release delay
// - release delay accepts 0 to 10 parallel-clock cycles
// - per-link readback of cycles from local edge to first data
// - latency readback wraps at the multiframe length in parallel clocks
// - parallel clock is the lane byte rate divided by four
// - rotate and trip flags are sticky until the sticky clear bit is written
// - lock and window flags update on every phase check
module jesd_deterministic_latency_ctrl
   import jdl_pkg::*;
(
   input wire logic ref_clk_in, // parallel clock, 10 MHz
   input wire logic nrst_in, // async reset, active low
   input wire logic [11:0] addr_in, // register address
   input wire logic [7:0] wdata_in, // register write data
   input wire logic wr_in, // write strobe
   input wire logic rd_in, // read strobe
   output logic [7:0] rdata_out, // read data, cycle after rd_in
   input wire logic sysref_in, // sysref pin, asynchronous
   input wire logic [1:0] sync_check_in, // per pair phase check pulse
   input wire logic [1:0] sync_aligned_in, // per pair aligned at check
   input wire logic [1:0] sync_rotated_in, // per pair rotation pulse
   input wire logic [1:0] sync_wlim_in, // per pair error beyond window
   input wire logic [1:0] ilas_done_in, // per link ILAS to data transition
   input wire logic [1:0] lanes_arrived_in, // per link all lanes hold data
   input wire logic [1:0] link_active_in, // per link link is up
   input wire logic [1:0] sync_err_in, // per link lane error request
   output logic [1:0] sync_err_out, // per link error on sync request
   output logic [1:0] buf_read_en_out, // per link receive buffer read
   output logic [1:0] lmfc_edge_out, // per link local multiframe edge
   output logic irq_out // sync event interrupt
);
   logic [2:0] sub_global;
   logic [2:0] next_sub_global;
   logic [7:0] link_cfg;
   logic [7:0] next_link_cfg;
   logic [7:0] framing;
   logic [7:0] next_framing;
   logic [7:0] mf_delay [2];
   logic [7:0] next_mf_delay [2];
   logic [7:0] rx_buffer_release_delay [2];
   logic [7:0] next_rbd [2];
   logic [7:0] rdata;
   logic [7:0] next_rdata;
   logic sticky_clr;
   logic [1:0] en_wr;
   logic [1:0] st_wr;
   logic sysref_meta;
   logic sysref_sync;
   logic sysref_prev;
   logic [5:0] fr_phase;
   logic [5:0] next_fr_phase;
   logic [1:0] hit;
   logic [1:0] next_edge_q;
   logic [1:0] edge_q;
   logic [1:0] next_err;
   logic [1:0] err_q;
   logic [2:0] octets;
   logic [2:0] fpp;
   logic [5:0] k_len;
   logic [5:0] mf_len;
   logic sc1;
   logic sysref_edge;
   logic gate_err;
   sync_flags_type flags [2];
   logic [3:0] enable [2];
   logic [3:0] status [2];
   logic [1:0] irq;
   // declared ahead of the read mux that reads the latency
   lmfc_if lif [2] ();

   // four octets per lane per parallel clock, so 4/F frames
   function automatic logic [2:0] frames_per_pclk(input logic [2:0] f);
      logic [2:0] r;
      r = 3'h1;
      if (f == 3'h1) begin
         r = 3'h4;
      end else if (f == 3'h2) begin
         r = 3'h2;
      end
      return r;
   endfunction : frames_per_pclk

   function automatic logic [5:0] phase_step(input logic [5:0] ph, input logic [2:0] step,
      input logic [5:0] k);
      logic [6:0] s;
      s = {1'b0, ph} + {4'h0, step};
      if (s >= {1'b0, k}) begin
         s = s - {1'b0, k};
      end
      return s[5:0];
   endfunction : phase_step

   // local edge falls in the first pclk whose frame span starts at or after the delayed phase
   function automatic logic lmfc_hit(input logic [5:0] ph, input logic [4:0] d,
      input logic [5:0] k, input logic [2:0] step);
      logic [6:0] t;
      t = {1'b0, ph} + {1'b0, k} - {2'h0, d};
      if (t >= {1'b0, k}) begin
         t = t - {1'b0, k};
      end
      return t < {4'h0, step};
   endfunction : lmfc_hit

   function automatic logic [3:0] clamp_rbd(input logic [7:0] v);
      logic [7:0] c;
      c = (v > `RBD_MAX) ? `RBD_MAX : v;
      return c[3:0];
   endfunction : clamp_rbd

   // framing decode: F in [2:0], K-1 in [7:3]
   always_comb begin
      logic [8:0] prod;
      prod = 9'h000;
      octets = framing[2:0];
      fpp = frames_per_pclk(octets);
      k_len = {1'b0, framing[7:3]} + 6'h01;
      prod = {3'h0, k_len} * {6'h00, octets};
      mf_len = prod[7:2];
      sc1 = (sub_global == `SUBCLASS_MAX);
      gate_err = (sub_global == 3'h0) && (octets == 3'h1);
      sysref_edge = sysref_sync && !sysref_prev;
   end

   // register writes and read mux
   always_comb begin
      next_sub_global = sub_global;
      next_link_cfg = link_cfg;
      next_framing = framing;
      next_mf_delay = mf_delay;
      next_rbd = rx_buffer_release_delay;
      sticky_clr = 1'b0;
      en_wr = 2'b00;
      st_wr = 2'b00;
      next_rdata = 8'h00;
      if (wr_in) begin
         case (addr_in)
            `ADDR_IRQ_EN_A: en_wr[0] = 1'b1;
            `ADDR_IRQ_EN_B: en_wr[1] = 1'b1;
            `ADDR_IRQ_ST_A: st_wr[0] = 1'b1;
            `ADDR_IRQ_ST_B: st_wr[1] = 1'b1;
            `ADDR_SYNC_CTRL: sticky_clr = wdata_in[`FLD_STICKY_CLR];
            `ADDR_SUBCLASS: begin
               // an unsupported subclass keeps the old value
               if (wdata_in[2:0] <= `SUBCLASS_MAX) begin
                  next_sub_global = wdata_in[2:0];
               end
            end
            `ADDR_LINK_CFG: begin
               next_link_cfg[4:0] = wdata_in[4:0];
               if (wdata_in[7:5] <= `SUBCLASS_MAX) begin
                  next_link_cfg[7:5] = wdata_in[7:5];
               end
            end
            `ADDR_MFDEL_L0: next_mf_delay[0] = wdata_in;
            `ADDR_MFDEL_L1: next_mf_delay[1] = wdata_in;
            `ADDR_RBD_L0: next_rbd[0] = wdata_in;
            `ADDR_RBD_L1: next_rbd[1] = wdata_in;
            `ADDR_FRAMING: next_framing = wdata_in;
            default: begin
            end
         endcase
      end
      if (rd_in) begin
         case (addr_in)
            `ADDR_IRQ_EN_A: next_rdata = {4'h0, enable[0]};
            `ADDR_IRQ_EN_B: next_rdata = {4'h0, enable[1]};
            `ADDR_IRQ_ST_A: next_rdata = {4'h0, status[0]};
            `ADDR_IRQ_ST_B: next_rdata = {4'h0, status[1]};
            `ADDR_SYNC_FLAGS: next_rdata = {flags[1], flags[0]};
            `ADDR_SUBCLASS: next_rdata = {5'h00, sub_global};
            `ADDR_LAT_L0: next_rdata = {2'h0, lif[0].latency};
            `ADDR_LAT_L1: next_rdata = {2'h0, lif[1].latency};
            `ADDR_MFDEL_L0: next_rdata = mf_delay[0];
            `ADDR_MFDEL_L1: next_rdata = mf_delay[1];
            `ADDR_RBD_L0: next_rdata = rx_buffer_release_delay[0];
            `ADDR_RBD_L1: next_rdata = rx_buffer_release_delay[1];
            `ADDR_LINK_CFG: next_rdata = link_cfg;
            `ADDR_FRAMING: next_rdata = framing;
            default: next_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         sub_global <= `RST_SUBCLASS;
         link_cfg <= `RST_LINK_CFG;
         framing <= `RST_FRAMING;
         mf_delay[0] <= `RST_MFDEL;
         mf_delay[1] <= `RST_MFDEL;
         rx_buffer_release_delay[0] <= `RST_RBD;
         rx_buffer_release_delay[1] <= `RST_RBD;
         rdata <= 8'h00;
      end else begin
         sub_global <= next_sub_global;
         link_cfg <= next_link_cfg;
         framing <= next_framing;
         mf_delay <= next_mf_delay;
         rx_buffer_release_delay <= next_rbd;
         rdata <= next_rdata;
      end
   end

   // sysref synchroniser; the edge is taken from the second and third stages
   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         sysref_meta <= 1'b0;
         sysref_sync <= 1'b0;
         sysref_prev <= 1'b0;
      end else begin
         sysref_meta <= sysref_in;
         sysref_sync <= sysref_meta;
         sysref_prev <= sysref_sync;
      end
   end

   // one phase counter for both pairs and links keeps them mutually aligned
   always_comb begin
      next_fr_phase = phase_step(fr_phase, fpp, k_len);
      if (sc1 && sysref_edge) begin
         next_fr_phase = 6'h00;
      end
      for (int i = 0; i < 2; i++) begin
         hit[i] = lmfc_hit(fr_phase, mf_delay[i][4:0], k_len, fpp);
      end
      next_edge_q = hit;
      next_err = sync_err_in & {2{!gate_err}};
   end

   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         fr_phase <= 6'h00;
         edge_q <= 2'b00;
         err_q <= 2'b00;
      end else begin
         fr_phase <= next_fr_phase;
         edge_q <= next_edge_q;
         err_q <= next_err;
      end
   end

   for (genvar g = 0; g < 2; g++) begin : g_link
      assign lif[g].lmfc_edge = hit[g];
      assign lif[g].ilas_done = ilas_done_in[g];
      assign lif[g].lanes_arrived = lanes_arrived_in[g];
      assign lif[g].active = link_active_in[g];
      assign lif[g].rx_buffer_release_delay = clamp_rbd(rx_buffer_release_delay[g]);
      assign lif[g].mf_len = mf_len;
      assign buf_read_en_out[g] = lif[g].release_en;

      link_release_timer u_link (
         .ref_clk_in(ref_clk_in),
         .nrst_in(nrst_in),
         .lk(lif[g])
      );

      sync_irq_pair u_pair (
         .ref_clk_in(ref_clk_in),
         .nrst_in(nrst_in),
         .check_in(sync_check_in[g]),
         .aligned_in(sync_aligned_in[g]),
         .rotated_in(sync_rotated_in[g]),
         .wlim_in(sync_wlim_in[g]),
         .sticky_clr_in(sticky_clr),
         .en_wr_in(en_wr[g]),
         .st_wr_in(st_wr[g]),
         .wdata_in(wdata_in[3:0]),
         .flags_out(flags[g]),
         .enable_out(enable[g]),
         .status_out(status[g]),
         .irq_out(irq[g])
      );
   end

   assign rdata_out = rdata;
   assign sync_err_out = err_q;
   assign lmfc_edge_out = edge_q;
   assign irq_out = |irq;

   property p_subclass_legal;
      @(posedge ref_clk_in) disable iff (!nrst_in)
      (sub_global <= `SUBCLASS_MAX) && (link_cfg[7:5] <= `SUBCLASS_MAX);
   endproperty
   a_subclass_legal: assert property (p_subclass_legal) else $error("bad subclass");
   property p_sc0_free_run;
      @(posedge ref_clk_in) disable iff (!nrst_in)
      (nrst_in && sub_global == 3'h0 && !wr_in) |=>
         (fr_phase == phase_step($past(fr_phase), fpp, k_len));
   endproperty
   a_sc0_free_run: assert property (p_sc0_free_run) else $error("sysref acted in sc0");
   property p_sc1_align;
      @(posedge ref_clk_in) disable iff (!nrst_in)
      (sc1 && sysref_edge) |=> (fr_phase == 6'h00);
   endproperty
   a_sc1_align: assert property (p_sc1_align) else $error("sysref not aligned");
   property p_err_gate;
      @(posedge ref_clk_in) disable iff (!nrst_in)
      (gate_err && !wr_in) |=> (sync_err_out == 2'b00);
   endproperty
   a_err_gate: assert property (p_err_gate) else $error("error reported in sc0 F1");
   property p_err_pass;
      @(posedge ref_clk_in) disable iff (!nrst_in)
      (!gate_err && !wr_in) |=> (sync_err_out == $past(sync_err_in));
   endproperty
   a_err_pass: assert property (p_err_pass) else $error("sync error dropped");
   property p_rbd_clamped;
      @(posedge ref_clk_in) disable iff (!nrst_in)
      (lif[0].rx_buffer_release_delay <= `RBD_MAX) && (lif[1].rx_buffer_release_delay <= `RBD_MAX);
   endproperty
   a_rbd_clamped: assert property (p_rbd_clamped) else $error("release delay above ten");
   property p_read_answer;
      @(posedge ref_clk_in) disable iff (!nrst_in)
      (rd_in && addr_in == `ADDR_RBD_L0 && !wr_in) |=> (rdata_out == rx_buffer_release_delay[0]);
   endproperty
   a_read_answer: assert property (p_read_answer) else $error("read data wrong");
endmodule : jesd_deterministic_latency_ctrl

/* testbench/tx_link_model.sv */
// transmitter-side link model: bring-up, lane arrival and end of ILAS for both links
module tx_link_model (
   input wire logic ref_clk_in, // parallel clock
   input wire logic start_in, // begin link bring-up
   output logic [1:0] active_out, // links up
   output logic [1:0] arrived_out, // all lanes hold data
   output logic [1:0] ilas_done_out // ILAS to first data, pulse
);
   timeunit 1ns;
   timeprecision 1ns;
   int n = 0;
   // both links see the same fixed delay, well inside the variation budget
   always @(posedge ref_clk_in) begin
      n <= start_in ? n + 1 : 0;
      active_out <= {2{start_in}};
      ilas_done_out <= {2{start_in && n == 3}};
      arrived_out <= {2{start_in && n >= 4}};
   end
endmodule : tx_link_model

/* testbench/test_jesd_deterministic_latency_ctrl.sv */
// register-level bench of the latency controller with a transmitter model
`include "jdl_cfg.svh"
module test_jesd_deterministic_latency_ctrl;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, nrst = 0, wr_s = 0, rd_s = 0, sysref = 0, start = 0, irq;
   logic [11:0] addr = '0;
   logic [7:0] wdata = '0, rdata;
   logic [1:0] chk = '0, al = '0, rot = '0, wl = '0, serr = '0;
   logic [1:0] serr_o, buf_en, edge_o, act, arr, ilas;
   int errors = 0, total_checks = 0;
   localparam int min_dly = 3, max_dly = 11;
   always #50 clk = ~clk;
   tx_link_model partner (.ref_clk_in(clk), .start_in(start), .active_out(act),
      .arrived_out(arr), .ilas_done_out(ilas));
   jesd_deterministic_latency_ctrl DUT (.ref_clk_in(clk), .nrst_in(nrst), .addr_in(addr),
      .wdata_in(wdata), .wr_in(wr_s), .rd_in(rd_s), .rdata_out(rdata), .sysref_in(sysref),
      .sync_check_in(chk), .sync_aligned_in(al), .sync_rotated_in(rot), .sync_wlim_in(wl),
      .ilas_done_in(ilas), .lanes_arrived_in(arr), .link_active_in(act), .sync_err_in(serr),
      .sync_err_out(serr_o), .buf_read_en_out(buf_en), .lmfc_edge_out(edge_o),
      .irq_out(irq));
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask : check
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_s <= 1;
      @(posedge clk);
      wr_s <= 0;
   endtask : wr
   task automatic rd(input logic [11:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd_s <= 1;
      @(posedge clk);
      rd_s <= 0;
      @(negedge clk);
      d = rdata;
   endtask : rd
   task automatic rc(input logic [11:0] a, input logic [7:0] e);
      logic [7:0] d;
      rd(a, d);
      check(d, e);
   endtask : rc
   task automatic ev(input int p, input logic a, input logic w, input logic r);
      @(posedge clk);
      chk[p] <= 1;
      al[p] <= a;
      wl[p] <= w;
      rot[p] <= r;
      @(posedge clk);
      chk <= 0;
      rot <= 0;
      repeat (2) @(negedge clk);
   endtask : ev
   // cycles until the next local multiframe edge of link b, capped
   task automatic gap(input int b, output int n);
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (edge_o[b] !== 1'b1 && n < 50);
   endtask : gap
   task automatic finish_test();
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : finish_test
   initial begin
      repeat (5000) @(posedge clk);
      errors++;
      finish_test();
   end
   initial begin
      logic [7:0] d, d1;
      int n;
      repeat (3) @(posedge clk);
      nrst <= 1;
      rc(`ADDR_SUBCLASS, 8'h00);
      rc(`ADDR_LINK_CFG, 8'h0f);
      rc(`ADDR_IRQ_EN_A, 8'h00);
      rc(12'h123, 8'h00);
      wr(`ADDR_SUBCLASS, 8'h02);
      rc(`ADDR_SUBCLASS, 8'h00);
      @(posedge clk);
      serr <= 2'b11;
      repeat (3) @(negedge clk);
      check(8'(serr_o), 8'h00);
      wr(`ADDR_SUBCLASS, 8'h01);
      rc(`ADDR_SUBCLASS, 8'h01);
      check(8'(serr_o), 8'h03);
      @(posedge clk);
      serr <= 2'b00;
      $display("test config done");
      for (int p = 0; p < 2; p++) begin
         wr(p ? `ADDR_IRQ_EN_B : `ADDR_IRQ_EN_A, p ? 8'h0f : 8'h01);
         ev(p, 1, 0, 0);
         check(8'(irq), 8'h01);
         rc(p ? `ADDR_IRQ_ST_B : `ADDR_IRQ_ST_A, p ? 8'h09 : 8'h01);
         rd(`ADDR_SYNC_FLAGS, d);
         check(8'(d[p*4 +: 4]), 8'h09);
         wr(p ? `ADDR_IRQ_ST_B : `ADDR_IRQ_ST_A, p ? 8'h0f : 8'h01);
         rc(p ? `ADDR_IRQ_ST_B : `ADDR_IRQ_ST_A, 8'h00);
         check(8'(irq), 8'h00);
         ev(p, 0, 1, 1);
         rd(`ADDR_SYNC_FLAGS, d);
         check(8'(d[p*4 +: 4]), 8'h07);
         rc(p ? `ADDR_IRQ_ST_B : `ADDR_IRQ_ST_A, p ? 8'h07 : 8'h01);
         wr(p ? `ADDR_IRQ_ST_B : `ADDR_IRQ_ST_A, p ? 8'h0f : 8'h01);
         wr(`ADDR_SYNC_CTRL, 8'h20);
         rd(`ADDR_SYNC_FLAGS, d);
         check(8'(d[p*4 +: 4]), 8'h02);
         rc(p ? `ADDR_IRQ_ST_B : `ADDR_IRQ_ST_A, 8'h00);
      end
      $display("test irq done");
      wr(`ADDR_RBD_L0, 8'h0a);
      rc(`ADDR_RBD_L0, 8'h0a);
      wr(`ADDR_MFDEL_L0, 8'h08);
      gap(1, n);
      gap(0, n);
      check(8'(n), 8'h02);
      gap(1, n);
      check(8'(n), 8'h06);
      wr(`ADDR_SUBCLASS, 8'h00);
      gap(1, n);
      repeat (3) @(posedge clk);
      sysref <= 1;
      gap(1, n);
      check(8'(n), 8'h06);
      @(posedge clk);
      sysref <= 0;
      wr(`ADDR_SUBCLASS, 8'h01);
      gap(1, n);
      @(posedge clk);
      sysref <= 1;
      gap(1, n);
      check(8'(n), 8'h05);
      @(posedge clk);
      sysref <= 0;
      $display("test multiframe done");
      wr(`ADDR_MFDEL_L1, 8'(((min_dly - 1) * 4) % 32));
      wr(`ADDR_RBD_L1, 8'((max_dly + 1) - (min_dly - 1)));
      @(posedge clk);
      start <= 1;
      repeat (3) @(negedge clk);
      check(8'(buf_en), 8'h00);
      n = 0;
      while (buf_en !== 2'b11 && n < 40) begin
         @(negedge clk);
         n++;
      end
      check(8'(buf_en), 8'h03);
      rd(`ADDR_LAT_L0, d);
      check(8'(d < 8'h08), 8'h01);
      rd(`ADDR_LAT_L1, d1);
      check(d1, d);
      @(posedge clk);
      start <= 0;
      repeat (3) @(negedge clk);
      check(8'(buf_en), 8'h00);
      $display("test release done");
      wr(`ADDR_FRAMING, 8'h7c);
      gap(1, n);
      gap(1, n);
      check(8'(n), 8'h10);
      $display("test framing done");
      finish_test();
   end
endmodule : test_jesd_deterministic_latency_ctrl
